// >>> rtl/stac_ctrl.sv
// Software trigger acquisition controller, top level.
// Assumes host commands are single-cycle pulses on this clock.
`timescale 1ns/1ps
`default_nettype none
module stac_ctrl
   import stac_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic [1:0]                trigger_target_select,
   input  wire logic                      trigger_gate_switch,
   input  wire logic [1:0]                trigger_origin_select,
   input  wire logic                      exposure_length_policy,
   input  wire logic                      capture_run_policy,
   input  wire logic [stac_pkg::EXP_W-1:0] exposure_length_setting,
   input  wire logic                      capture_rate_ceiling_enable,
   input  wire logic [stac_pkg::PER_W-1:0] capture_rate_ceiling,
   input  wire logic [stac_pkg::PER_W-1:0] config_min_period,
   input  wire logic                      capture_arm_cmd,
   input  wire logic                      capture_disarm_cmd,
   input  wire logic                      host_fire_cmd,
   input  wire logic                      readout_done,
   output logic                           capture_readiness_flag,
   output logic                           exposure_active,
   output logic                           readout_start,
   output logic                           readout_active,
   output logic                           armed
);
   import stac_pkg::*;

   // ********************************************************
   // State
   // ********************************************************
   typedef struct packed {
      stac_state_t             state;
      logic                    stay_armed;
      logic [EXP_W-1:0]        exp_cnt;
      logic [RDO_W-1:0]        rdo_cnt;
      logic                    rdo_start;
   } stac_ctl_t;

   stac_ctl_t st_ff;
   stac_ctl_t nxt_st;
   logic      sw_trig_cfg;
   logic      rate_ok;
   logic      fire_ok;
   logic      busy;

   // configuration decode, host sets these fields
   assign sw_trig_cfg = (trigger_target_select == TRIG_ACQ_START) &&
                        trigger_gate_switch &&
                        (trigger_origin_select == TRIG_SRC_SOFT) &&
                        (exposure_length_policy == EXP_TIMED);

   // Readout overlaps nothing; a new exposure waits for it
   assign busy = (st_ff.state == ST_EXPOSE) ||
                 (st_ff.state == ST_READOUT);

   // low from exposure start until readout ends and rate allows
   assign capture_readiness_flag = (st_ff.state == ST_ARMED) && rate_ok
                                   && sw_trig_cfg;

   // fires when not ready are dropped
   // Disarm in the same cycle wins over a fire
   assign fire_ok = host_fire_cmd && capture_readiness_flag &&
                    !capture_disarm_cmd;

   // ********************************************************
   // Rate limiter
   // ********************************************************
   // ceiling period used when slower
   // maximum rate clamps a faster ceiling
   // only maximum applies with ceiling off
   stac_rate_limit #(
      .W           (PER_W)
   ) u_rate (
      .clock       (clock),
      .rst         (rst),
      .ce          (ce),
      .start       (fire_ok),
      .ceil_en     (capture_rate_ceiling_enable),
      .ceil_period (capture_rate_ceiling),
      .min_period  (config_min_period),
      .rate_ok     (rate_ok)
   );

   // ********************************************************
   // Sequencer
   // ********************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdo_start = 1'b0;
      unique case (st_ff.state)
         ST_DISARMED: begin
            if (capture_arm_cmd) begin
               nxt_st.state = ST_ARMED;
               nxt_st.stay_armed = 1'b1;
            end
         end
         ST_ARMED: begin
            if (capture_disarm_cmd) begin
               nxt_st.state = ST_DISARMED;
               nxt_st.stay_armed = 1'b0;
            end else if (fire_ok) begin
               nxt_st.state = ST_EXPOSE;
               nxt_st.exp_cnt = (exposure_length_setting == EXP_ZERO) ?
                                EXP_ONE : exposure_length_setting;
               // one-shot uses up its single fire
               nxt_st.stay_armed = (capture_run_policy == RUN_CONTINUOUS);
            end
         end
         ST_EXPOSE: begin
            if (capture_disarm_cmd) begin
               nxt_st.stay_armed = 1'b0;
            end
            if (st_ff.exp_cnt == EXP_ONE) begin
               nxt_st.state = ST_READOUT;
               nxt_st.rdo_start = 1'b1;
               nxt_st.rdo_cnt = RDO_CYCLES;
            end else begin
               nxt_st.exp_cnt = st_ff.exp_cnt - EXP_ONE;
            end
         end
         ST_READOUT: begin
            if (capture_disarm_cmd) begin
               nxt_st.stay_armed = 1'b0;
            end
            if (st_ff.rdo_cnt != RDO_ZERO) begin
               nxt_st.rdo_cnt = st_ff.rdo_cnt - RDO_ONE;
            end
            if (readout_done || (st_ff.rdo_cnt == RDO_ONE)) begin
               nxt_st.state = (st_ff.stay_armed && !capture_disarm_cmd) ?
                              ST_ARMED : ST_DISARMED;
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_ff <= '{state: ST_DISARMED, stay_armed: 1'b0,
                    exp_cnt: EXP_ZERO, rdo_cnt: RDO_ZERO,
                    rdo_start: 1'b0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign exposure_active = (st_ff.state == ST_EXPOSE);
   assign readout_active  = (st_ff.state == ST_READOUT);
   assign readout_start   = st_ff.rdo_start;
   assign armed           = (st_ff.state == ST_ARMED) || (busy &&
                            st_ff.stay_armed);

   // ********************************************************
   // Checks
   // ********************************************************
   sequence s_fire;
      fire_ok;
   endsequence

   property p_fire_starts;
      @(posedge clock) disable iff (rst)
      s_fire and ce |=> exposure_active;
   endproperty
   a_fire_starts: assert property (p_fire_starts)
      else $error("accepted fire did not start exposure");

   property p_drop_unready;
      @(posedge clock) disable iff (rst)
      host_fire_cmd && !capture_readiness_flag && !exposure_active &&
      !readout_active && ce |=> !exposure_active;
   endproperty
   a_drop_unready: assert property (p_drop_unready)
      else $error("fire while not ready started exposure");

   sequence s_exp_hold;
      exposure_active [*4] ##1 !exposure_active;
   endsequence

   // Frozen cycles would stretch the count, so ce low disables
   property p_exp_len;
      @(posedge clock) disable iff (rst || !ce)
      s_fire and exposure_length_setting == 24'h000004 |=> s_exp_hold;
   endproperty
   a_exp_len: assert property (p_exp_len)
      else $error("exposure shorter than setting");

   property p_exp_to_rdo;
      @(posedge clock) disable iff (rst)
      $fell(exposure_active) |-> readout_active && readout_start;
   endproperty
   a_exp_to_rdo: assert property (p_exp_to_rdo)
      else $error("exposure end did not start readout");

   property p_ready_low_busy;
      @(posedge clock) disable iff (rst)
      (exposure_active || readout_active) |-> !capture_readiness_flag;
   endproperty
   a_ready_low_busy: assert property (p_ready_low_busy)
      else $error("ready during exposure or readout");

   property p_one_shot_disarm;
      @(posedge clock) disable iff (rst)
      s_fire and ce && capture_run_policy == RUN_ONE_SHOT
      |=> !armed;
   endproperty
   a_one_shot_disarm: assert property (p_one_shot_disarm)
      else $error("one-shot kept armed after fire");

   property p_cont_rearm;
      @(posedge clock) disable iff (rst)
      s_fire and ce && capture_run_policy == RUN_CONTINUOUS &&
      !capture_disarm_cmd |=> armed;
   endproperty
   a_cont_rearm: assert property (p_cont_rearm)
      else $error("continuous lost arm after fire");

   property p_disarm;
      @(posedge clock) disable iff (rst)
      capture_disarm_cmd && ce && st_ff.state == ST_ARMED
      |=> !capture_readiness_flag && !armed;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("disarm left device ready");

   property p_rate;
      @(posedge clock) disable iff (rst || !ce)
      s_fire and config_min_period == 32'h00000028 &&
      !capture_rate_ceiling_enable |=> !rate_ok [*8] ##31 !rate_ok
      ##1 rate_ok;
   endproperty
   a_rate: assert property (p_rate)
      else $error("rate limit released early");
endmodule
`default_nettype wire

// >>> rtl/stac_pkg.sv
// Package for the software trigger acquisition controller.
// Assumes one clock domain; host commands arrive as one-cycle pulses.
package stac_pkg;
   // ********************************************************
   // Widths
   // ********************************************************
   localparam int EXP_W  = 24;
   localparam int PER_W  = 32;
   localparam int RDO_W  = 24;
   // ********************************************************
   // Configuration encodings
   // ********************************************************
   localparam logic [1:0] TRIG_ACQ_START = 2'h0;
   localparam logic [1:0] TRIG_SRC_SOFT  = 2'h0;
   localparam logic       EXP_TIMED      = 1'h0;
   localparam logic       RUN_ONE_SHOT   = 1'h0;
   localparam logic       RUN_CONTINUOUS = 1'h1;
   // ********************************************************
   // Reset values and counts
   // ********************************************************
   localparam logic [EXP_W-1:0] EXP_ZERO  = 24'h000000;
   localparam logic [EXP_W-1:0] EXP_ONE   = 24'h000001;
   localparam logic [PER_W-1:0] PER_ZERO  = 32'h00000000;
   localparam logic [PER_W-1:0] PER_ONE   = 32'h00000001;
   localparam logic [RDO_W-1:0] RDO_ZERO  = 24'h000000;
   localparam logic [RDO_W-1:0] RDO_ONE   = 24'h000001;
   // Readout length in cycles when the datapath gives no done
   localparam logic [RDO_W-1:0] RDO_CYCLES = 24'h000100;
   // ********************************************************
   // States
   // ********************************************************
   typedef enum logic [1:0] {
      ST_DISARMED = 2'b00,
      ST_ARMED    = 2'b01,
      ST_EXPOSE   = 2'b10,
      ST_READOUT  = 2'b11
   } stac_state_t;
endpackage

// >>> rtl/stac_rate_limit.sv
// Rate limiter: spacing counter between accepted triggers.
// Assumes periods in clock cycles; larger period means lower rate.
`timescale 1ns/1ps
`default_nettype none
module stac_rate_limit
   import stac_pkg::*;
#(
   parameter int W = stac_pkg::PER_W
)(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         start,
   input  wire logic         ceil_en,
   input  wire logic [W-1:0] ceil_period,
   input  wire logic [W-1:0] min_period,
   output logic              rate_ok
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } stac_rl_t;

   stac_rl_t st_ff;
   stac_rl_t nxt_st;
   logic [W-1:0] limit;

   // Larger of the two periods wins while ceil_en is set
   always_comb begin
      limit = min_period;
      if (ceil_en && (ceil_period > min_period)) begin
         limit = ceil_period;
      end
   end

   always_comb begin
      nxt_st = st_ff;
      if (start) begin
         nxt_st.cnt = (limit > PER_ONE) ? limit - PER_ONE : PER_ZERO;
      end else if (st_ff.cnt != PER_ZERO) begin
         nxt_st.cnt = st_ff.cnt - PER_ONE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign rate_ok = (st_ff.cnt == PER_ZERO);
endmodule
`default_nettype wire

// >>> verif/stac_ctrl_tb.sv
// Self-checking bench for the software trigger acquisition controller.
// Assumes one 200 MHz clock, async high reset, commands as 1-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module stac_ctrl_tb;
   import stac_pkg::*;
   // ********************************************************
   // Signals
   // ********************************************************
   localparam int N = 4;
   localparam int P = 40;
   logic             clock;
   logic             rst;
   logic             ce;
   logic [1:0]       tsel;
   logic             gate;
   logic [1:0]       osel;
   logic             epol;
   logic             run;
   logic             ceil_en;
   logic [PER_W-1:0] ceil_p;
   logic [EXP_W-1:0] elen;
   logic [PER_W-1:0] minp;
   logic             arm;
   logic             disarm;
   logic             fire;
   logic             rdone;
   logic             rdy;
   logic             exp_act;
   logic             rd_start;
   logic             rd_act;
   logic             armed;
   int               err_total;
   int               compares;
   int               cyc;
   int               t_fire;
   int               n;
   int               t0;
   int               t1;
   int               t2;

   stac_ctrl i_dut (
      .clock                       (clock),
      .rst                         (rst),
      .ce                          (ce),
      .trigger_target_select       (tsel),
      .trigger_gate_switch         (gate),
      .trigger_origin_select       (osel),
      .exposure_length_policy      (epol),
      .capture_run_policy          (run),
      .exposure_length_setting     (elen),
      .capture_rate_ceiling_enable (ceil_en),
      .capture_rate_ceiling        (ceil_p),
      .config_min_period           (minp),
      .capture_arm_cmd             (arm),
      .capture_disarm_cmd          (disarm),
      .host_fire_cmd               (fire),
      .readout_done                (rdone),
      .capture_readiness_flag      (rdy),
      .exposure_active             (exp_act),
      .readout_start               (rd_start),
      .readout_active              (rd_act),
      .armed                       (armed)
   );
   // ********************************************************
   // Clock, cycle count, watchdog
   // ********************************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   // Whole run is a few hundred cycles; this is about a hundred times that
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   // ********************************************************
   // Tasks
   // ********************************************************
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      @(posedge clock);
      #1 s = 1'b1;
      @(posedge clock);
      #1 s = 1'b0;
   endtask
   // Fire, then follow exposure and readout when it is expected to start
   task automatic capture(input logic exp_start);
      t_fire = cyc;
      pulse(fire);
      check("exposure_active", exp_act, exp_start);
      if (exp_start) begin
         check("ready_in_exposure", rdy, 1'b0);
         n = 0;
         while (exp_act === 1'b1 && n < 1000) begin
            n++;
            @(posedge clock);
            #1;
         end
         check("exposure_cycles", n, elen);
         check("readout_start", rd_start, 1'b1);
         check("readout_active", rd_act, 1'b1);
         // readout ends before return
         // Fire during readout must be dropped
         fire = 1'b1;
         rdone = 1'b1;
         @(posedge clock);
         #1 fire = 1'b0;
         rdone = 1'b0;
         check("readout_ended", rd_act, 1'b0);
         check("busy_fire_dropped", exp_act, 1'b0);
      end
   endtask
   task automatic wait_rdy(output int d);
      n = 0;
      while (rdy !== 1'b1 && n < 2000) begin
         n++;
         @(posedge clock);
         #1;
      end
      d = cyc - t_fire;
   endtask
   task automatic summarize();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      {ce, gate} = 2'h3;
      {arm, disarm, fire, rdone, ceil_en, rst} = 6'h01;
      {tsel, osel, epol, run} = {TRIG_ACQ_START, TRIG_SRC_SOFT,
                                 EXP_TIMED, RUN_ONE_SHOT};
      ceil_p = 32'h00000000;
      elen = EXP_W'(N);
      minp = PER_W'(P);
      err_total = 0;
      compares = 0;
      repeat (6) @(posedge clock);
      #1 rst = 1'b0;
      check("reset_outputs", {rdy, exp_act, rd_start, rd_act, armed}, 0);
      ce = 1'b0;
      pulse(arm);
      check("arm_frozen", armed, 1'b0);
      ce = 1'b1;
      capture(1'b0);
      pulse(arm);
      check("armed", armed, 1'b1);
      check("ready_armed", rdy, 1'b1);
      capture(1'b1);
      check("one_shot_disarmed", armed, 1'b0);
      capture(1'b0);
      pulse(arm);
      wait_rdy(t0);
      capture(1'b1);
      // Let the rate counter expire so only config can hold ready low
      repeat (P) @(posedge clock);
      #1;
      // Each wrong configuration field must hold readiness low
      for (int i = 0; i < 4; i++) begin
         case (i)
            0: tsel = 2'h1;
            1: gate = 1'b0;
            2: osel = 2'h1;
            default: epol = ~EXP_TIMED;
         endcase
         pulse(arm);
         check("ready_bad_config", rdy, 1'b0);
         capture(1'b0);
         pulse(disarm);
         {tsel, gate, osel, epol} = {TRIG_ACQ_START, 1'b1,
                                     TRIG_SRC_SOFT, EXP_TIMED};
      end
      // Continuous mode and rate limits, periods in cycles
      run = RUN_CONTINUOUS;
      pulse(arm);
      capture(1'b1);
      wait_rdy(t0);
      check("cont_armed", armed, 1'b1);
      // Fire edge is two after t_fire, ready seen one edge early
      check("floor_period", t0, P + 1);
      ceil_en = 1'b1;
      ceil_p = 32'h0000000A;
      capture(1'b1);
      wait_rdy(t1);
      check("ceiling_clamped", t1, t0);
      ceil_p = 32'h00000064;
      elen = 24'h000002;
      capture(1'b1);
      wait_rdy(t2);
      check("ceiling_period", t2, t0 + 60);
      capture(1'b1);
      capture(1'b0);
      wait_rdy(t1);
      pulse(disarm);
      check("disarmed", armed, 1'b0);
      capture(1'b0);
      summarize();
   end
endmodule
`default_nettype wire
